// ### dv/program_rom_model.sv
`timescale 1ns/10ps
// program rom, sixteen pages of 64 bytes, content follows the address
module program_rom_model (
  // rom pins
  input wire logic [9:0] rom_addr,
  output logic [7:0] rom_data
);
  // every word differs from its page neighbours and its block twins
  assign rom_data =
    rom_addr[7:0] ^ {rom_addr[9:8], rom_addr[9:8], 4'h5};
endmodule

// ### dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic ref_clk, resetn, op_valid, op_ready;
  branch_pkg::op_t op_kind;
  logic [6:0] op_field;
  logic [9:0] long_target, rom_addr, pc, push_addr, exp_pc;
  logic [3:0] acc, mem_digit;
  logic [7:0] rom_data, out_latch, exp_latch;
  logic push_valid, out_latch_load, call_misuse;
  logic [31:0] seed;
  int err_count, comparisons;

  paged_branch_target_unit dut (.ref_clk(ref_clk), .resetn(resetn),
    .op_valid(op_valid), .op_ready(op_ready), .op_kind(op_kind),
    .op_field(op_field), .long_target(long_target), .acc(acc),
    .mem_digit(mem_digit), .rom_addr(rom_addr), .rom_data(rom_data),
    .pc(pc), .push_valid(push_valid), .push_addr(push_addr),
    .out_latch(out_latch), .out_latch_load(out_latch_load),
    .call_misuse(call_misuse));
  program_rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));

  function automatic logic [7:0] rom_fn(input logic [9:0] a);
    return a[7:0] ^ {a[9:8], a[9:8], 4'h5};
  endfunction

  function automatic logic [9:0] jump_fn(input logic [9:0] n,
                                         input logic [6:0] f);
    if (f[5:0] == 6'h3f) return n;
    if (n[9:7] == 3'h1) return {n[9:7], f};
    return {n[9:6], f[5:0]};
  endfunction

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("counts: %0d compares, %0d errors", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // issue one instruction and check every output against the model
  task automatic exec(input branch_pkg::op_t k, input logic [6:0] f,
                      input logic [9:0] t, input logic [3:0] a, m);
    logic [9:0] n, np;
    logic two, call;
    n = exp_pc + 10'h001;
    two = k == branch_pkg::OP_INDIRECT_JUMP || k == branch_pkg::OP_TABLE_LOAD;
    call = k == branch_pkg::OP_SHORT_CALL || k == branch_pkg::OP_LONG_CALL;
    case (k)
      branch_pkg::OP_LOCAL_JUMP: np = jump_fn(n, f);
      branch_pkg::OP_SHORT_CALL: np = {4'h2, f[5:0]};
      branch_pkg::OP_LONG_CALL: np = t;
      branch_pkg::OP_INDIRECT_JUMP:
        np = {n[9:8], rom_fn({n[9:8], a, m})};
      default: np = n;
    endcase
    if (k == branch_pkg::OP_TABLE_LOAD)
      exp_latch = rom_fn({n[9:8], a, m});
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_field <= f;
    long_target <= t;
    acc <= a;
    mem_digit <= m;
    #1;
    chk(op_ready, 1'b1);
    chk(rom_addr, {n[9:8], a, m});
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
    chk(push_valid, call);
    if (call) chk(push_addr, n);
    chk(call_misuse,
      k == branch_pkg::OP_SHORT_CALL && n[9:7] == 3'h1);
    if (two) begin
      chk(op_ready, 1'b0);
      @(posedge ref_clk);
      #1;
    end
    chk(out_latch_load, k == branch_pkg::OP_TABLE_LOAD);
    chk(pc, np);
    chk(out_latch, exp_latch);
    exp_pc = np;
  endtask

  task automatic corner(input logic [9:0] t, input branch_pkg::op_t k,
                        input logic [6:0] f, input logic [3:0] a, m);
    exec(branch_pkg::OP_LONG_CALL, 7'h00, t, 4'h0, 4'h0);
    exec(k, f, 10'h000, a, m);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    stop_test();
  end

  initial begin
    branch_pkg::op_t k;
    logic [6:0] f;
    resetn = 1'b0;
    op_valid = 1'b0;
    op_kind = branch_pkg::OP_NONE;
    op_field = 7'h00;
    long_target = 10'h000;
    acc = 4'h0;
    mem_digit = 4'h0;
    seed = 32'hcb44;
    exp_pc = 10'h000;
    exp_latch = 8'h00;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    #1;
    chk(pc, 10'h000);
    chk(out_latch, 8'h00);
    corner(10'h07f, branch_pkg::OP_LOCAL_JUMP, 7'h45, 4'h0, 4'h0);
    corner(10'h0ff, branch_pkg::OP_LOCAL_JUMP, 7'h45, 4'h0, 4'h0);
    corner(10'h0c0, branch_pkg::OP_LOCAL_JUMP, 7'h00, 4'h0, 4'h0);
    corner(10'h140, branch_pkg::OP_LOCAL_JUMP, 7'h3f, 4'h0, 4'h0);
    corner(10'h0ff, branch_pkg::OP_SHORT_CALL, 7'h10, 4'h0, 4'h0);
    corner(10'h085, branch_pkg::OP_SHORT_CALL, 7'h3e, 4'h0, 4'h0);
    corner(10'h07f, branch_pkg::OP_SHORT_CALL, 7'h05, 4'h0, 4'h0);
    corner(10'h0ff, branch_pkg::OP_INDIRECT_JUMP, 7'h00, 4'h3, 4'hc);
    corner(10'h3ff, branch_pkg::OP_INDIRECT_JUMP, 7'h00, 4'ha, 4'h5);
    corner(10'h2ff, branch_pkg::OP_TABLE_LOAD, 7'h00, 4'hf, 4'hf);
    corner(10'h245, branch_pkg::OP_TABLE_LOAD, 7'h00, 4'h7, 4'h1);
    $display("test corners done");
    repeat (300) begin
      seed = xs(seed);
      k = branch_pkg::op_t'(3'(seed % 6));
      f = seed[14:8];
      if (k == branch_pkg::OP_SHORT_CALL && f[5:0] == 6'h3f)
        f[0] = 1'b0;
      if (k == branch_pkg::OP_SHORT_CALL && exp_pc[9:7] == 3'h1)
        k = branch_pkg::OP_LONG_CALL;
      if (k == branch_pkg::OP_SHORT_CALL && exp_pc == 10'h07f)
        k = branch_pkg::OP_LONG_CALL;
      exec(k, f, seed[31:22], seed[19:16], seed[23:20]);
    end
    $display("test random done");
    stop_test();
  end
endmodule

// ### verilog/branch_pkg.sv
package branch_pkg;
  // program address layout
  localparam int PC_W = 10;
  localparam int OFS_W = 6;
  localparam int PAGE_W = 4;
  localparam int BLK_W = 2;
  localparam int IDX_W = 8;
  localparam int WORD_W = 8;
  localparam int NPAGES = 16;
  localparam logic [PAGE_W-1:0] PAGE_SUB_LO = 4'h2;
  localparam logic [PAGE_W-1:0] PAGE_SUB_HI = 4'h3;
  localparam logic [PAGE_W-1:0] PAGE_CALL = 4'h2;
  localparam logic [OFS_W-1:0] OFS_LAST = 6'h3f;
  localparam logic [PC_W-1:0] PC_RESET = 10'h000;
  localparam logic [PC_W-1:0] PC_ONE = 10'h001;
  localparam logic [WORD_W-1:0] LATCH_RESET = 8'h00;
  // subroutine-page jump field: low bit of page plus offset
  localparam int SUBJ_W = OFS_W + 1;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_LOCAL_JUMP = 3'b001,
    OP_SHORT_CALL = 3'b010,
    OP_INDIRECT_JUMP = 3'b011,
    OP_TABLE_LOAD = 3'b100,
    OP_LONG_CALL = 3'b101
  } op_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_PTR = 2'b01,
    ST_LOOK = 2'b10
  } state_t;
endpackage

// ### verilog/paged_branch_target_unit.sv
`timescale 1ns/10ps
module paged_branch_target_unit (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // instruction issue
  input wire logic op_valid,
  output logic op_ready,
  input wire branch_pkg::op_t op_kind,
  input wire logic [branch_pkg::SUBJ_W-1:0] op_field,
  input wire logic [branch_pkg::PC_W-1:0] long_target,
  // accumulator and memory digit
  input wire logic [3:0] acc,
  input wire logic [3:0] mem_digit,
  // program rom
  output logic [branch_pkg::PC_W-1:0] rom_addr,
  input wire logic [branch_pkg::WORD_W-1:0] rom_data,
  // program counter and stack push
  output logic [branch_pkg::PC_W-1:0] pc,
  output logic push_valid,
  output logic [branch_pkg::PC_W-1:0] push_addr,
  // output latch
  output logic [branch_pkg::WORD_W-1:0] out_latch,
  output logic out_latch_load,
  // misuse flag
  output logic call_misuse
);
  branch_pkg::state_t state_q, state_d;
  logic [branch_pkg::PC_W-1:0] pc_q, pc_d;
  logic [branch_pkg::PC_W-1:0] pc_inc;
  logic [branch_pkg::PC_W-1:0] exec_q;
  logic [branch_pkg::WORD_W-1:0] latch_q;
  logic [branch_pkg::WORD_W-1:0] rd_data;
  logic [branch_pkg::PC_W-1:0] rd_addr;
  logic rd_en;
  logic push_q, load_q, misuse_q;
  logic [branch_pkg::PC_W-1:0] push_addr_q;

  function automatic logic [branch_pkg::PAGE_W-1:0] page_of(
    input logic [branch_pkg::PC_W-1:0] a);
    page_of = a[branch_pkg::PC_W-1:branch_pkg::OFS_W];
  endfunction

  function automatic logic [branch_pkg::BLK_W-1:0] block_of(
    input logic [branch_pkg::PC_W-1:0] a);
    block_of = a[branch_pkg::PC_W-1:branch_pkg::IDX_W];
  endfunction

  function automatic logic in_sub_pages(
    input logic [branch_pkg::PC_W-1:0] a);
    in_sub_pages = (page_of(a) == branch_pkg::PAGE_SUB_LO) ||
      (page_of(a) == branch_pkg::PAGE_SUB_HI);
  endfunction

  // incremented counter used by the jump, call, rom address and return address logic below
  pc_incr #(
    .W(branch_pkg::PC_W)
  ) u_incr (
    .pc_in(pc_q),
    .pc_out(pc_inc)
  );

  wire logic sub_now = in_sub_pages(pc_inc);
  wire logic [branch_pkg::OFS_W-1:0] fld_ofs =
    op_field[branch_pkg::OFS_W-1:0];
  // last offset is never produced by a jump encoding
  wire logic fld_last = (fld_ofs == branch_pkg::OFS_LAST);
  wire logic [branch_pkg::OFS_W-1:0] jmp_ofs =
    fld_last ? pc_inc[branch_pkg::OFS_W-1:0] : fld_ofs;
  wire logic [branch_pkg::PAGE_W-1:0] jmp_page =
    sub_now ? {branch_pkg::PAGE_SUB_LO[branch_pkg::PAGE_W-1:1],
               op_field[branch_pkg::OFS_W]}
            : page_of(pc_inc);
  wire logic [branch_pkg::PC_W-1:0] jump_tgt =
    fld_last ? pc_inc : {jmp_page, jmp_ofs};
  wire logic [branch_pkg::PC_W-1:0] call_tgt =
    fld_last ? pc_inc : {branch_pkg::PAGE_CALL, fld_ofs};
  wire logic [branch_pkg::IDX_W-1:0] am_idx = {acc, mem_digit};
  wire logic [branch_pkg::PC_W-1:0] am_addr =
    {block_of(pc_inc), am_idx};
  wire logic [branch_pkg::PC_W-1:0] ind_tgt =
    {block_of(exec_q), rd_data};
  wire logic issue = op_valid && (state_q == branch_pkg::ST_FETCH);
  wire logic is_ind = op_kind == branch_pkg::OP_INDIRECT_JUMP;
  wire logic is_tab = op_kind == branch_pkg::OP_TABLE_LOAD;

  assign op_ready = (state_q == branch_pkg::ST_FETCH);
  assign rd_en = issue && (is_ind || is_tab);
  assign rd_addr = am_addr;

  rom_reader #(
    .AW(branch_pkg::PC_W),
    .DW(branch_pkg::WORD_W)
  ) u_rom (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rom_addr(rom_addr),
    .rom_data(rom_data),
    .rd_data(rd_data)
  );

  always_comb begin
    state_d = state_q;
    pc_d = pc_q;
    unique case (state_q)
      branch_pkg::ST_FETCH: begin
        if (op_valid) begin
          pc_d = pc_inc;
          unique case (op_kind)
            branch_pkg::OP_LOCAL_JUMP: pc_d = jump_tgt;
            branch_pkg::OP_SHORT_CALL: pc_d = call_tgt;
            branch_pkg::OP_LONG_CALL: pc_d = long_target;
            branch_pkg::OP_INDIRECT_JUMP: state_d = branch_pkg::ST_PTR;
            branch_pkg::OP_TABLE_LOAD: state_d = branch_pkg::ST_LOOK;
            default: pc_d = pc_inc;
          endcase
        end
      end
      branch_pkg::ST_PTR: begin
        pc_d = ind_tgt;
        state_d = branch_pkg::ST_FETCH;
      end
      branch_pkg::ST_LOOK: begin
        state_d = branch_pkg::ST_FETCH;
      end
      default: state_d = branch_pkg::ST_FETCH;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= branch_pkg::ST_FETCH;
      pc_q <= branch_pkg::PC_RESET;
    end else begin
      state_q <= state_d;
      pc_q <= pc_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      exec_q <= branch_pkg::PC_RESET;
      push_q <= 1'b0;
      push_addr_q <= branch_pkg::PC_RESET;
      misuse_q <= 1'b0;
    end else begin
      push_q <= issue && ((op_kind == branch_pkg::OP_SHORT_CALL) ||
        (op_kind == branch_pkg::OP_LONG_CALL));
      misuse_q <= issue && (op_kind == branch_pkg::OP_SHORT_CALL) &&
        sub_now;
      if (issue) begin
        exec_q <= pc_inc;
        push_addr_q <= pc_inc;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= branch_pkg::LATCH_RESET;
      load_q <= 1'b0;
    end else begin
      load_q <= (state_q == branch_pkg::ST_LOOK);
      if (state_q == branch_pkg::ST_LOOK) begin
        latch_q <= rd_data;
      end
    end
  end

  assign pc = pc_q;
  assign push_valid = push_q;
  assign push_addr = push_addr_q;
  assign out_latch = latch_q;
  assign out_latch_load = load_q;
  assign call_misuse = misuse_q;

  AST_SHORT_CALL_PAGE: assert property (@(posedge ref_clk) disable iff (!resetn)
    issue && op_kind == branch_pkg::OP_SHORT_CALL && !fld_last |=>
    page_of(pc_q) == branch_pkg::PAGE_CALL)
    else $error("short call left page two");

  AST_CALL_PUSH: assert property (@(posedge ref_clk) disable iff (!resetn)
    issue && op_kind == branch_pkg::OP_SHORT_CALL |=>
    push_valid && push_addr == $past(pc_inc))
    else $error("short call did not push return");

  AST_JUMP_NOT_LAST: assert property (@(posedge ref_clk) disable iff (!resetn)
    issue && op_kind == branch_pkg::OP_LOCAL_JUMP && !fld_last |=>
    pc_q[branch_pkg::OFS_W-1:0] != branch_pkg::OFS_LAST)
    else $error("local jump reached last word");

  AST_JUMP_PAGE: assert property (@(posedge ref_clk) disable iff (!resetn)
    issue && op_kind == branch_pkg::OP_LOCAL_JUMP && !sub_now |=>
    page_of(pc_q) == page_of($past(pc_inc)))
    else $error("local jump left its page");

  AST_SUB_JUMP: assert property (@(posedge ref_clk) disable iff (!resetn)
    issue && op_kind == branch_pkg::OP_LOCAL_JUMP && sub_now |=>
    in_sub_pages(pc_q))
    else $error("subroutine page jump escaped");

  sequence ind_seq;
    issue && is_ind ##1 state_q == branch_pkg::ST_PTR;
  endsequence

  AST_IND_BLOCK: assert property (@(posedge ref_clk) disable iff (!resetn)
    ind_seq |=> block_of(pc_q) == block_of(exec_q) &&
    state_q == branch_pkg::ST_FETCH)
    else $error("indirect jump changed block");

  AST_IND_TARGET: assert property (@(posedge ref_clk) disable iff (!resetn)
    ind_seq |=> pc_q[branch_pkg::IDX_W-1:0] == $past(rd_data))
    else $error("indirect target not pointer");

  AST_LOOKUP: assert property (@(posedge ref_clk) disable iff (!resetn)
    issue && is_tab |=> ##1 out_latch_load && out_latch == $past(rd_data))
    else $error("lookup byte not latched");

  AST_INCR: assert property (@(posedge ref_clk) disable iff (!resetn)
    issue && op_kind == branch_pkg::OP_NONE |=> pc_q == $past(pc_q) +
    branch_pkg::PC_ONE)
    else $error("counter did not advance");
endmodule

// ### verilog/pc_incr.sv
`timescale 1ns/10ps
// program counter increment with page carry
module pc_incr #(
  parameter int W = 10
) (
  // address in
  input wire logic [W-1:0] pc_in,
  // address out
  output logic [W-1:0] pc_out
);
  // carry runs out of the offset into the page number
  assign pc_out = pc_in + W'(1);
endmodule

// ### verilog/rom_reader.sv
`timescale 1ns/10ps
// registered read port of the program rom
module rom_reader #(
  parameter int AW = 10,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // request
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  // rom pins
  output logic [AW-1:0] rom_addr,
  input wire logic [DW-1:0] rom_data,
  // registered result
  output logic [DW-1:0] rd_data
);
  assign rom_addr = rd_addr;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= rom_data;
    end
  end
endmodule
